// ### logic/ismar_pkg.sv
// package: register map, control fields, status codes and carriers of the two-wire slave
package ismar_pkg;
    localparam logic [7:0] ADDR_OWN = 8'hC8;
    localparam logic [7:0] ADDR_EXT = 8'hC9;
    localparam logic [7:0] ADDR_DATA = 8'hCA;
    localparam logic [7:0] ADDR_CTRL = 8'hCB;
    localparam logic [7:0] ADDR_STAT = 8'hCC;
    localparam logic [7:0] ADDR_SRST = 8'hCD;
    localparam int CTL_IEN = 7;
    localparam int CTL_ENAB = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STP = 4;
    localparam int CTL_INTERRUPT_FLAG = 3;
    localparam int CTL_AAK = 2;
    localparam int SAR_GCE = 0;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_COUNT = 4'h9;
    localparam logic [7:0] ST_IDLE = 8'hF8;
    localparam logic [7:0] ST_TX_ADDR = 8'hA8;
    localparam logic [7:0] ST_ARB_TX = 8'hB0;
    localparam logic [7:0] ST_TX_DATA = 8'hB8;
    localparam logic [7:0] ST_TX_NACK = 8'hC0;
    localparam logic [7:0] ST_TX_LAST = 8'hC8;
    localparam logic [7:0] ST_RX_ADDR = 8'h60;
    localparam logic [7:0] ST_ARB_RX = 8'h68;
    localparam logic [7:0] ST_RX_GC = 8'h70;
    localparam logic [7:0] ST_ARB_GC = 8'h78;
    localparam logic [7:0] ST_RX_ACK = 8'h80;
    localparam logic [7:0] ST_RX_NACK = 8'h88;
    localparam logic [7:0] ST_GC_ACK = 8'h90;
    localparam logic [7:0] ST_GC_NACK = 8'h98;
    localparam logic [7:0] ST_RX_END = 8'hA0;

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_RX, S_TX, S_TX_ACK} ismar_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ismar_cpu_req_t;

    typedef struct packed {
        logic scl_out;
        logic scl_oe_n;
        logic sda_out;
        logic sda_oe_n;
    } ismar_pin_drv_t;
endpackage

// ### logic/ismar_slave.sv
// two-wire slave engine with own-address registers and processor register file
`timescale 1ns/1ps
module ismar_slave
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic arb_lost,
    input wire ismar_pkg::ismar_cpu_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    output ismar_pkg::ismar_pin_drv_t pin_drv,
    output logic [7:0] clk_div
);
    import ismar_pkg::*;

    // link domain: bus data sampled on the rising bus clock
    logic link_bit;
    logic link_tgl;

    always_ff @(posedge scl_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_bit <= 1'b0;
            link_tgl <= 1'b0;
        end
        else
        begin
            link_bit <= sda_in;
            link_tgl <= ~link_tgl;
        end
    end

    // system domain synchronisers; link_bit is stable for several clk
    // cycles after the toggle is seen, so it is read only then
    logic scl_meta, scl_s, scl_d;
    logic sda_meta, sda_s, sda_d;
    logic tgl_meta, tgl_s, tgl_d;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            tgl_meta <= 1'b0;
            tgl_s <= 1'b0;
            tgl_d <= 1'b0;
        end
        else
        begin
            scl_meta <= scl_clk;
            scl_s <= scl_meta;
            scl_d <= scl_s;
            sda_meta <= sda_in;
            sda_s <= sda_meta;
            sda_d <= sda_s;
            tgl_meta <= link_tgl;
            tgl_s <= tgl_meta;
            tgl_d <= tgl_s;
        end
    end

    // register file
    logic [7:0] own_addr;
    logic [7:0] ext_addr;
    logic [7:0] data_byte;
    logic [7:0] status;
    logic ctl_ien, ctl_enab, start_request, stop_request, interrupt_flag, ack_enable;

    // engine state
    ismar_state_t state;
    ismar_state_t after_state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] txsh;
    logic ack_phase, raise_pend, pend_keep, gc_mode, sel10, idle_clr;
    logic tx_wait, last_byte, master_nack, sda_rel;
    logic [7:0] pend_code;

    // bus events
    wire start_ev = scl_s && scl_d && sda_d && !sda_s;
    wire stop_ev = scl_s && scl_d && !sda_d && sda_s;
    wire scl_fall = scl_d && !scl_s;
    wire bit_ev = tgl_s ^ tgl_d;

    // processor decode
    wire wr_own = cpu_req.wr && cpu_req.addr == ADDR_OWN;
    wire wr_ext = cpu_req.wr && cpu_req.addr == ADDR_EXT;
    wire wr_data = cpu_req.wr && cpu_req.addr == ADDR_DATA;
    wire wr_ctl = cpu_req.wr && cpu_req.addr == ADDR_CTRL;
    wire wr_div = cpu_req.wr && cpu_req.addr == ADDR_STAT;
    wire soft_rst = cpu_req.wr && cpu_req.addr == ADDR_SRST;
    wire interrupt_flag_clr = wr_ctl && !cpu_req.wdata[CTL_INTERRUPT_FLAG];
    wire [7:0] ctl_read = {ctl_ien, ctl_enab, start_request, stop_request,
                           interrupt_flag, ack_enable, 2'b00};
    wire [7:0] rd_mux = (cpu_req.addr == ADDR_OWN) ? own_addr :
                        (cpu_req.addr == ADDR_EXT) ? ext_addr :
                        (cpu_req.addr == ADDR_DATA) ? data_byte :
                        (cpu_req.addr == ADDR_CTRL) ? ctl_read :
                        (cpu_req.addr == ADDR_STAT) ? {status[7:3], 3'b000} :
                        8'h00;

    // address matching
    wire rw_read = shreg[0];
    wire ten_bit = own_addr[7:3] == TEN_BIT_PREFIX;
    wire hi_match = shreg[7:1] == own_addr[7:1];
    wire gc_hit = own_addr[SAR_GCE] && shreg == GC_ADDR;
    wire respond = ctl_enab && ack_enable;

    // a stop request from software acts as a received stop
    wire stop_like = (stop_ev || stop_request) && state != S_IDLE;
    wire run = ctl_enab && !soft_rst;
    wire clk_ok = run && !start_ev && !stop_like;
    wire receiving = state == S_ADDR || state == S_ADDR2 || state == S_RX;
    wire rx_bit = clk_ok && bit_ev && receiving && !ack_phase && cnt < BITS_PER_BYTE;
    wire tx_bit = clk_ok && bit_ev && (state == S_TX || state == S_TX_ACK) && !tx_wait;
    wire byte_end = clk_ok && scl_fall && receiving && !ack_phase && cnt == BITS_PER_BYTE;
    wire ack_end = clk_ok && scl_fall && ack_phase;
    wire tx_load = clk_ok && state == S_TX && tx_wait && !interrupt_flag;
    wire tx_shift = clk_ok && scl_fall && state == S_TX && !tx_wait
                    && cnt != 4'h0 && cnt < BITS_PER_BYTE;
    wire tx_done = clk_ok && scl_fall && state == S_TX && !tx_wait && cnt == BITS_PER_BYTE;
    wire tx_ack_end = clk_ok && scl_fall && state == S_TX_ACK && cnt == ACK_COUNT;
    wire tx_stop = last_byte || master_nack;
    // the stop or restart comes after the first scl rise of a byte, already counted
    wire a0_hit = run && (stop_like || start_ev) && state == S_RX
                  && cnt <= 4'h1 && !ack_phase;
    wire idle_on_clear = run && interrupt_flag_clr && interrupt_flag && idle_clr && state == S_RX;
    wire [7:0] tx_code = master_nack ? ST_TX_NACK : (last_byte ? ST_TX_LAST : ST_TX_DATA);
    wire interrupt_flag_set = (ack_end && raise_pend) || tx_ack_end || a0_hit;
    wire keep_code = ack_end && raise_pend && pend_keep;
    wire [7:0] set_code = a0_hit ? ST_RX_END : (tx_ack_end ? tx_code : pend_code);
    // keep scl low one more cycle while a new sda level reaches the pin
    wire hold = ((interrupt_flag || tx_wait) && state != S_IDLE)
                || (sda_rel != pin_drv.sda_oe_n);

    // decision taken at the falling clock that ends a received byte
    logic dec_ack, dec_raise, dec_keep, dec_gc, dec_sel10, dec_idle_clr;
    logic [7:0] dec_code;
    ismar_state_t dec_state;

    always_comb
    begin
        dec_ack = 1'b0;
        dec_raise = 1'b0;
        dec_keep = 1'b0;
        dec_gc = gc_mode;
        dec_sel10 = sel10;
        dec_idle_clr = 1'b0;
        dec_code = ST_IDLE;
        dec_state = S_IDLE;
        case (state)
            S_ADDR:
            begin
                if (respond && !ten_bit && hi_match && rw_read)
                begin
                    dec_ack = 1'b1;
                    dec_raise = 1'b1;
                    dec_code = arb_lost ? ST_ARB_TX : ST_TX_ADDR;
                    dec_state = S_TX;
                end
                else if (respond && !ten_bit && hi_match)
                begin
                    dec_ack = 1'b1;
                    dec_raise = 1'b1;
                    dec_code = arb_lost ? ST_ARB_RX : ST_RX_ADDR;
                    dec_state = S_RX;
                    dec_gc = 1'b0;
                end
                else if (respond && gc_hit)
                begin
                    dec_ack = 1'b1;
                    dec_raise = 1'b1;
                    dec_code = arb_lost ? ST_ARB_GC : ST_RX_GC;
                    dec_state = S_RX;
                    dec_gc = 1'b1;
                end
                else if (respond && ten_bit && hi_match && !rw_read)
                begin
                    dec_ack = 1'b1;
                    dec_state = S_ADDR2;
                end
                else if (respond && ten_bit && hi_match && sel10)
                begin
                    dec_ack = 1'b1;
                    dec_raise = 1'b1;
                    dec_keep = 1'b1;
                    dec_state = S_TX;
                end
            end
            S_ADDR2:
            begin
                if (respond && shreg == ext_addr)
                begin
                    dec_ack = 1'b1;
                    dec_raise = 1'b1;
                    dec_code = arb_lost ? ST_ARB_RX : ST_RX_ADDR;
                    dec_state = S_RX;
                    dec_gc = 1'b0;
                    dec_sel10 = 1'b1;
                end
            end
            S_RX:
            begin
                dec_raise = 1'b1;
                dec_state = S_RX;
                dec_ack = ack_enable;
                if (ack_enable)
                    dec_code = gc_mode ? ST_GC_ACK : ST_RX_ACK;
                else
                begin
                    dec_code = gc_mode ? ST_GC_NACK : ST_RX_NACK;
                    dec_idle_clr = 1'b1;
                end
            end
            default:
            begin
                dec_state = S_IDLE;
            end
        endcase
    end

    // bus engine
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            after_state <= S_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            txsh <= 8'h00;
            ack_phase <= 1'b0;
            raise_pend <= 1'b0;
            pend_keep <= 1'b0;
            pend_code <= ST_IDLE;
            gc_mode <= 1'b0;
            sel10 <= 1'b0;
            idle_clr <= 1'b0;
            tx_wait <= 1'b0;
            last_byte <= 1'b0;
            master_nack <= 1'b0;
            sda_rel <= 1'b1;
        end
        else if (!run)
        begin
            state <= S_IDLE;
            ack_phase <= 1'b0;
            tx_wait <= 1'b0;
            idle_clr <= 1'b0;
            sel10 <= 1'b0;
            sda_rel <= 1'b1;
        end
        else if (stop_like)
        begin
            state <= start_ev ? S_ADDR : S_IDLE;
            cnt <= 4'h0;
            sel10 <= 1'b0;
            ack_phase <= 1'b0;
            tx_wait <= 1'b0;
            sda_rel <= 1'b1;
        end
        else if (start_ev)
        begin
            // a restart keeps sel10 so a 10-bit read can follow
            state <= S_ADDR;
            cnt <= 4'h0;
            ack_phase <= 1'b0;
            tx_wait <= 1'b0;
            sda_rel <= 1'b1;
        end
        else
        begin
            if (rx_bit)
            begin
                shreg <= {shreg[6:0], link_bit};
                cnt <= cnt + 4'h1;
            end
            if (tx_bit)
                cnt <= cnt + 4'h1;
            if (tx_bit && state == S_TX_ACK)
                master_nack <= link_bit;
            if (byte_end && (dec_ack || dec_raise))
            begin
                ack_phase <= 1'b1;
                sda_rel <= !dec_ack;
                raise_pend <= dec_raise;
                pend_code <= dec_code;
                pend_keep <= dec_keep;
                after_state <= dec_state;
                gc_mode <= dec_gc;
                sel10 <= dec_sel10;
                idle_clr <= dec_idle_clr;
            end
            else if (byte_end)
                state <= S_IDLE;
            if (ack_end)
            begin
                ack_phase <= 1'b0;
                sda_rel <= 1'b1;
                cnt <= 4'h0;
                state <= after_state;
                tx_wait <= after_state == S_TX;
            end
            if (tx_load)
            begin
                txsh <= {data_byte[6:0], 1'b0};
                sda_rel <= data_byte[7];
                cnt <= 4'h0;
                tx_wait <= 1'b0;
                last_byte <= !ack_enable;
            end
            if (tx_shift)
            begin
                txsh <= {txsh[6:0], 1'b0};
                sda_rel <= txsh[7];
            end
            if (tx_done)
            begin
                sda_rel <= 1'b1;
                state <= S_TX_ACK;
            end
            if (tx_ack_end)
            begin
                state <= tx_stop ? S_IDLE : S_TX;
                tx_wait <= !tx_stop;
                cnt <= 4'h0;
            end
            if (idle_on_clear)
                state <= S_IDLE;
        end
    end

    // processor registers
    wire next_interrupt_flag = soft_rst ? 1'b0 : interrupt_flag_set ? 1'b1 : interrupt_flag_clr ? 1'b0 : interrupt_flag;
    wire [7:0] next_status = soft_rst ? ST_IDLE :
                             interrupt_flag_set ? (keep_code ? status : set_code) :
                             interrupt_flag_clr ? ST_IDLE : status;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            own_addr <= RST_REG;
            ext_addr <= RST_REG;
            data_byte <= RST_REG;
            ctl_ien <= 1'b0;
            ctl_enab <= 1'b0;
            start_request <= 1'b0;
            stop_request <= 1'b0;
            interrupt_flag <= 1'b0;
            ack_enable <= 1'b0;
            status <= ST_IDLE;
            clk_div <= RST_REG;
            cpu_rdata <= 8'h00;
        end
        else
        begin
            if (wr_own)
                own_addr <= cpu_req.wdata;
            if (wr_ext)
                ext_addr <= cpu_req.wdata;
            if (byte_end && state == S_RX)
                data_byte <= shreg;
            else if (wr_data)
                data_byte <= cpu_req.wdata;
            if (wr_div)
                clk_div <= cpu_req.wdata;
            if (wr_ctl)
            begin
                ctl_ien <= cpu_req.wdata[CTL_IEN];
                ctl_enab <= cpu_req.wdata[CTL_ENAB];
                ack_enable <= cpu_req.wdata[CTL_AAK];
            end
            // writing 0 to start or stop has no effect; stop acts once
            start_request <= !soft_rst && (start_request || (wr_ctl && cpu_req.wdata[CTL_STA]));
            stop_request <= !soft_rst && wr_ctl && cpu_req.wdata[CTL_STP];
            interrupt_flag <= next_interrupt_flag;
            status <= next_status;
            cpu_rdata <= cpu_req.rd ? rd_mux : 8'h00;
        end
    end

    // open-drain pins; clock is only grabbed while already low so no
    // spurious falling edge is made
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_drv <= '{scl_out: 1'b0, scl_oe_n: 1'b1, sda_out: 1'b0, sda_oe_n: 1'b1};
        else
            pin_drv <= '{scl_out: 1'b0,
                         scl_oe_n: !(hold && (!scl_s || !pin_drv.scl_oe_n)),
                         sda_out: 1'b0,
                         sda_oe_n: sda_rel};
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_tx_wait_done;
        state == S_TX && tx_wait && !interrupt_flag && clk_ok;
    endsequence

    sequence s_first_bit_out;
        ##1 !tx_wait ##1 pin_drv.sda_oe_n == $past(data_byte[7], 2);
    endsequence

    AST_TX_ADDR: assert property ($rose(interrupt_flag) && status == ST_TX_ADDR |-> state == S_TX)
        else $error("status A8h without transmit mode");
    AST_ARB_TX: assert property ($rose(interrupt_flag) && status == ST_ARB_TX |-> state == S_TX)
        else $error("status B0h without transmit mode");
    AST_TX_LOAD: assert property (s_tx_wait_done |-> s_first_bit_out)
        else $error("first data bit not driven after flag clear");
    AST_TX_LAST: assert property ($rose(interrupt_flag) && status == ST_TX_LAST |-> state == S_IDLE)
        else $error("status C8h without return to idle");
    AST_TX_NACK: assert property (tx_ack_end && master_nack |=> interrupt_flag && status == ST_TX_NACK && state == S_IDLE)
        else $error("unacknowledged byte not reported as C0h");
    AST_TX_STOP: assert property (stop_ev && run && (state == S_TX || state == S_TX_ACK) |=> state == S_IDLE)
        else $error("stop in transmit did not return to idle");
    AST_RX_DATA: assert property (byte_end && state == S_RX && ack_enable |=> ##1 !pin_drv.sda_oe_n)
        else $error("received byte not acknowledged");
    AST_RX_NACK: assert property (byte_end && state == S_RX && !ack_enable |=> ##1 pin_drv.sda_oe_n)
        else $error("not-acknowledge not sent with ack_enable clear");
    AST_NO_RESPONSE: assert property (byte_end && state == S_ADDR && !ack_enable |=> ##1 pin_drv.sda_oe_n)
        else $error("address acknowledged with ack_enable clear");
    AST_STRETCH: assert property ($rose(interrupt_flag) && state != S_IDLE && !scl_s
        |-> ##[1:2] !pin_drv.scl_oe_n)
        else $error("clock not held low while flag set");
    AST_REVERT: assert property ($fell(interrupt_flag) |-> status == ST_IDLE)
        else $error("status not F8h after flag clear");
    AST_SOFT_RESET: assert property (soft_rst |=> !interrupt_flag && !stop_request && !start_request && state == S_IDLE)
        else $error("soft reset left engine active");
    AST_STAT_LOW: assert property (cpu_req.rd && cpu_req.addr == ADDR_STAT |=> cpu_rdata[2:0] == 3'h0)
        else $error("status low bits not zero");

endmodule // ismar_slave

// ### bench/ismar_bus_master.sv
// behavioural bus master that drives the two-wire pins from the far side
`timescale 1ns/1ps
module ismar_bus_master
(
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_m,
    output logic sda_m
);
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // bounded wait on a stretched clock, so a stuck line cannot hang the run
    task automatic rise();
        int i;
        scl_m = 1'b1;
        i = 0;
        while (!scl_w && i < 500)
        begin
            #10;
            i++;
        end
        #40;
    endtask
    // hold data 30 ns past the fall so the synced lines never see a false start;
    // 160 ns low leaves room for the slave's late sda change and stretch grab
    task automatic xbit(input logic b, output logic s);
        #30;
        sda_m = b;
        #130;
        rise();
        s = sda_w;
        #40;
        scl_m = 1'b0;
    endtask
    task automatic start();
        sda_m = 1'b1;
        #80;
        rise();
        sda_m = 1'b0;
        #80;
        scl_m = 1'b0;
        #120;
    endtask
    task automatic stop();
        #30;
        sda_m = 1'b0;
        #130;
        rise();
        #40;
        sda_m = 1'b1;
        #80;
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic s;
        #120;
        for (int i = 7; i >= 0; i--) xbit(v[i], s);
        xbit(1'b1, ack);
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] v);
        logic s;
        #120;
        for (int i = 7; i >= 0; i--) xbit(1'b1, v[i]);
        xbit(ack, s);
    endtask
endmodule // ismar_bus_master

// ### bench/tb_ismar_slave.sv
// testbench: register access and slave transfers against a behavioural master
`timescale 1ns/1ps
module tb_ismar_slave;
    import ismar_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic arb_lost = 1'b0;
    logic scl_m, sda_m, a;
    logic [7:0] cpu_rdata, clk_div, d;
    ismar_cpu_req_t cpu_req = '0;
    ismar_pin_drv_t pin_drv;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    // open drain with pull-ups
    wire scl_w = scl_m & pin_drv.scl_oe_n;
    wire sda_w = sda_m & pin_drv.sda_oe_n;
    always #10 clk = ~clk;
    ismar_slave uut (.clk(clk), .rst_n(rst_n), .scl_clk(scl_w), .sda_in(sda_w),
        .arb_lost(arb_lost), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
        .pin_drv(pin_drv), .clk_div(clk_div));
    ismar_bus_master bfm (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        cpu_req <= '{1'b1, 1'b0, ad, dt};
        @(posedge clk);
        cpu_req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
        @(posedge clk);
        cpu_req <= '{1'b0, 1'b1, ad, 8'h00};
        @(posedge clk);
        cpu_req <= '0;
        #1;
        dt = cpu_rdata;
    endtask
    task automatic chkreg(input logic [7:0] ad, input logic [7:0] exp);
        rd(ad, d);
        chk($sformatf("register %h", ad), exp, d);
    endtask
    task automatic wait_flag();
        int i;
        i = 0;
        d = 8'h00;
        while (d[CTL_INTERRUPT_FLAG] !== 1'b1 && i < 400)
        begin
            rd(ADDR_CTRL, d);
            i++;
        end
        chk("interrupt_flag", 8'h01, {7'h00, d[CTL_INTERRUPT_FLAG]});
    endtask
    task automatic addr_phase(input logic [7:0] v, input logic [7:0] st);
        bfm.start();
        bfm.wbyte(v, a);
        chk("address ack", 8'h00, {7'h00, a});
        wait_flag();
        chkreg(ADDR_STAT, st);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #3;
        for (int i = 0; i < 4; i++) chkreg(ADDR_OWN + 8'(i), RST_REG);
        chkreg(ADDR_STAT, ST_IDLE);
        chkreg(8'h10, 8'h00);
        wr(ADDR_STAT, 8'h5A);
        chk("clk_div", 8'h5A, clk_div);
        chkreg(ADDR_STAT, ST_IDLE);
        $display("test registers done");
        wr(ADDR_OWN, 8'hA9);
        wr(ADDR_CTRL, 8'h44);
        chkreg(ADDR_OWN, 8'hA9);
        addr_phase(8'hA8, ST_RX_ADDR);
        chk("scl held", 8'h00, {7'h00, scl_w});
        wr(ADDR_CTRL, 8'h44);
        chkreg(ADDR_STAT, ST_IDLE);
        bfm.wbyte(8'h3C, a);
        wait_flag();
        chkreg(ADDR_STAT, ST_RX_ACK);
        chkreg(ADDR_DATA, 8'h3C);
        wr(ADDR_CTRL, 8'h44);
        bfm.stop();
        wait_flag();
        chkreg(ADDR_STAT, ST_RX_END);
        wr(ADDR_CTRL, 8'h44);
        $display("test receive done");
        arb_lost <= 1'b1;
        addr_phase(GC_ADDR, ST_ARB_GC);
        arb_lost <= 1'b0;
        wr(ADDR_CTRL, 8'h40);
        bfm.wbyte(8'h77, a);
        chk("data nack", 8'h01, {7'h00, a});
        wait_flag();
        chkreg(ADDR_STAT, ST_GC_NACK);
        wr(ADDR_CTRL, 8'h44);
        bfm.stop();
        $display("test general call done");
        addr_phase(8'hA9, ST_TX_ADDR);
        wr(ADDR_DATA, 8'h5A);
        wr(ADDR_CTRL, 8'h44);
        bfm.rbyte(1'b0, d);
        chk("sent byte", 8'h5A, d);
        wait_flag();
        chkreg(ADDR_STAT, ST_TX_DATA);
        wr(ADDR_DATA, 8'hC3);
        wr(ADDR_CTRL, 8'h40);
        bfm.rbyte(1'b0, d);
        chk("last byte", 8'hC3, d);
        wait_flag();
        chkreg(ADDR_STAT, ST_TX_LAST);
        wr(ADDR_CTRL, 8'h44);
        bfm.stop();
        arb_lost <= 1'b1;
        addr_phase(8'hA9, ST_ARB_TX);
        arb_lost <= 1'b0;
        wr(ADDR_DATA, 8'h81);
        wr(ADDR_CTRL, 8'h44);
        bfm.rbyte(1'b1, d);
        wait_flag();
        chkreg(ADDR_STAT, ST_TX_NACK);
        wr(ADDR_CTRL, 8'h44);
        bfm.stop();
        $display("test transmit done");
        wr(ADDR_CTRL, 8'h40);
        bfm.start();
        bfm.wbyte(8'hA8, a);
        chk("address ignored", 8'h01, {7'h00, a});
        bfm.stop();
        chkreg(ADDR_CTRL, 8'h40);
        wr(ADDR_CTRL, 8'h44);
        addr_phase(8'hA8, ST_RX_ADDR);
        wr(ADDR_CTRL, 8'h6C);
        wr(ADDR_SRST, 8'h00);
        chkreg(ADDR_CTRL, 8'h44);
        chkreg(ADDR_STAT, ST_IDLE);
        bfm.stop();
        $display("test soft reset done");
        wr(ADDR_OWN, 8'hF4);
        wr(ADDR_EXT, 8'h3C);
        bfm.start();
        bfm.wbyte(8'hF4, a);
        chk("first address byte ack", 8'h00, {7'h00, a});
        #200;
        chkreg(ADDR_CTRL, 8'h44);
        bfm.wbyte(8'h3C, a);
        chk("second address byte ack", 8'h00, {7'h00, a});
        wait_flag();
        chkreg(ADDR_STAT, ST_RX_ADDR);
        wr(ADDR_CTRL, 8'h44);
        bfm.start();
        wait_flag();
        chkreg(ADDR_STAT, ST_RX_END);
        wr(ADDR_CTRL, 8'h44);
        bfm.wbyte(8'hF5, a);
        chk("restart read ack", 8'h00, {7'h00, a});
        wait_flag();
        chkreg(ADDR_STAT, ST_IDLE);
        wr(ADDR_DATA, 8'h96);
        wr(ADDR_CTRL, 8'h44);
        bfm.rbyte(1'b0, d);
        chk("ten-bit byte", 8'h96, d);
        wait_flag();
        chkreg(ADDR_STAT, ST_TX_DATA);
        wr(ADDR_CTRL, 8'h44);
        bfm.stop();
        chk("idle after stop", 8'h01, {7'h00, uut.state == S_IDLE});
        $display("test ten-bit done");
        print_verdict();
    end
endmodule // tb_ismar_slave
